// ### design/sys_config.v
// reset-cause recording, watchdog, write-once options, clock output
// assumes: rstn is the power-on reset; all inputs synchronous to clk
//
// Summary of operation
// - read-only cause flags at bits 7,6,5,4,2,1
// - debug forced reset leaves all flags clear
// - cause address write restarts watchdog only
// - power-on sets power-on and low-voltage flags
// - low-voltage reset needs both enables and trip
// - other resets flag active causes only
// - watchdog flag; disabled watchdog never resets
// - illegal stop or background opcode resets device
// - low reset pin sets pin flag
// - force bit only by debug host, reads zero
// - debug one in force bit resets device
// - options readable, only first write honored
// - options bits 3 and 2 read zero
// - watchdog enable at bit 7, resets one
// - timeout select bit 6: 2^13 or 2^18
// - stop enable bit 5 resets zero
// - clock output enable bit 4 drives pin
// - divide field gives bus over twice value
// - enabled with zero divide holds pin low
// - clock generator request sets its flag
// - enabled clock output forces pin to output
`timescale 1ns/1ps
`default_nettype none
`include "sys_config_defines.vh"

module sys_config #(
	parameter integer WDOG_SHORT_CYCLES = `WDOG_SHORT_CYCLES,
	parameter integer WDOG_LONG_CYCLES  = `WDOG_LONG_CYCLES
) (
	input  wire       clk,
	input  wire       rstn,
	input  wire [1:0] reg_sel,
	input  wire       reg_wr,
	input  wire       reg_rd,
	input  wire [7:0] reg_wdata,
	output wire [7:0] reg_rdata,
	input  wire       dbg_wr,
	input  wire [1:0] dbg_sel,
	input  wire [7:0] dbg_wdata,
	input  wire       reset_pin_n,
	input  wire       clock_gen_reset_req,
	input  wire       illegal_opcode_req,
	input  wire       stop_exec,
	input  wire       background_instruction,
	input  wire       background_mode_enable,
	input  wire       low_voltage_trip,
	input  wire       low_voltage_reset_enable,
	input  wire       low_voltage_stop_enable,
	input  wire       port_data_out,
	input  wire       port_dir_out,
	output wire       shared_port_pin_out,
	output wire       shared_port_pin_oe,
	output wire       system_reset_n,
	output wire       stop_mode_enter,
	output wire       watchdog_enable,
	output wire       watchdog_timeout_select,
	output wire       stop_mode_enable
);

	// ----------------------------------------
	// local constants
	// ----------------------------------------
	// two states suffice: running, or held in reset
	localparam       ST_RUN  = 1'b0;  // normal operation
	localparam       ST_HOLD = 1'b1;  // device held in reset
	// limits worked out at full width, then cut to the counter width
	localparam [31:0] WDOG_SHORT_M1  = WDOG_SHORT_CYCLES - 1;
	localparam [31:0] WDOG_LONG_M1   = WDOG_LONG_CYCLES - 1;
	localparam [17:0] WDOG_SHORT_LIM = WDOG_SHORT_M1[17:0];
	localparam [17:0] WDOG_LONG_LIM  = WDOG_LONG_M1[17:0];

	// ----------------------------------------
	// functions
	// ----------------------------------------
	// register index match for a write or read strobe
	// one compare shared by every write decode; the read mux uses a case on reg_sel
	function hit;
		input       strobe;
		input [1:0] sel;
		input [1:0] idx;
		begin
			hit = strobe && (sel == idx);
		end
	endfunction

	// cause flags captured when a reset is entered
	function [7:0] cause_flags;
		input [7:0] prev;
		input       pin;
		input       wdog;
		input       illegal_opcode_flag;
		input       clock_generator_flag;
		input       low_voltage_reset;
		begin
			cause_flags = 8'h00;
			if (low_voltage_reset) begin
				// low voltage keeps power-on flag, sets its own flag, clears rest
				cause_flags[`BIT_POWER_ON]    = prev[`BIT_POWER_ON];
				cause_flags[`BIT_LOW_VOLTAGE] = 1'b1;
			end else begin
				cause_flags[`BIT_PIN]            = pin;
				cause_flags[`BIT_WATCHDOG]       = wdog;
				cause_flags[`BIT_ILLEGAL_OPCODE] = illegal_opcode_flag;
				cause_flags[`BIT_CLOCK_GEN]      = clock_generator_flag;
			end
		end
	endfunction

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg        state_ff;      // reset sequencer state
	reg        nxt_state;
	reg  [3:0] hold_cnt_ff;   // cycles spent in reset hold
	reg  [3:0] nxt_hold_cnt;
	reg  [7:0] flags_ff;      // reset_cause_flags
	reg  [7:0] nxt_flags;
	reg        sys_rst_n_ff;  // device reset out
	reg        watchdog_enable_ff;       // watchdog_enable
	reg        watchdog_timeout_select_ff;       // watchdog_timeout_select
	reg        stop_mode_enable_ff;      // stop_mode_enable
	reg        lock_ff;       // options already written
	reg        clk_en_ff;     // clock_output_enable
	reg  [2:0] clk_div_ff;    // clock_output_divide
	reg [17:0] wdog_cnt_ff;   // watchdog count
	reg  [7:0] rdata_ff;      // read data
	reg  [7:0] nxt_rdata;

	// ----------------------------------------
	// decodes and reset causes
	// ----------------------------------------
	wire running    = (state_ff == ST_RUN);
	wire wr_cause   = hit(reg_wr, reg_sel, `IDX_RESET_CAUSE);
	wire wr_options = hit(reg_wr, reg_sel, `IDX_SYSTEM_OPTIONS);
	wire wr_clkout  = hit(reg_wr, reg_sel, `IDX_CLOCK_OUTPUT);
	// user writes to the force register never reach this term
	wire dbg_force  = hit(dbg_wr, dbg_sel, `IDX_DEBUG_FORCE)
	                  && dbg_wdata[`BIT_FORCE_RESET];
	wire [17:0] wdog_lim = watchdog_timeout_select_ff ? WDOG_LONG_LIM : WDOG_SHORT_LIM;
	// timeout only counts while enabled; >= so a limit shortened by the
	// first options write still trips instead of waiting for a wrap
	wire wdog_to    = watchdog_enable_ff && (wdog_cnt_ff >= wdog_lim);
	wire pin_act    = ~reset_pin_n;
	// either enable alone leaves a supply trip harmless
	wire lvr_act    = low_voltage_trip && low_voltage_reset_enable
	                  && low_voltage_stop_enable;
	wire illegal_opcode_flag_act   = illegal_opcode_req
	                  || (stop_exec && !stop_mode_enable_ff)
	                  || (background_instruction && !background_mode_enable);
	// every cause, debug force included, enters the same hold
	wire any_cause  = pin_act || wdog_to || illegal_opcode_flag_act || clock_gen_reset_req
	                  || lvr_act || dbg_force;

	// ----------------------------------------
	// reset sequencer next state
	// ----------------------------------------
	// causes are sampled only while running; in the hold only pin and supply restart the count
	always @* begin
		nxt_state    = state_ff;
		nxt_hold_cnt = hold_cnt_ff;
		nxt_flags    = flags_ff;
		case (state_ff)
			ST_RUN: begin
				if (any_cause) begin
					// a forced reset alone yields all zero
					nxt_flags    = cause_flags(flags_ff, pin_act, wdog_to,
					                           illegal_opcode_flag_act, clock_gen_reset_req,
					                           lvr_act);
					nxt_state    = ST_HOLD;
					nxt_hold_cnt = 4'h0;
				end
			end
			ST_HOLD: begin
				if (pin_act || lvr_act) begin
					// held while the pin or supply stays bad
					nxt_hold_cnt = 4'h0;
				end else if (hold_cnt_ff == `RST_HOLD_CYCLES) begin
					nxt_state = ST_RUN;  // release device
				end else begin
					nxt_hold_cnt = hold_cnt_ff + 4'h1;
				end
			end
			default: begin
				nxt_state = ST_HOLD;
			end
		endcase
	end

	// ----------------------------------------
	// reset sequencer and cause flags
	// ----------------------------------------
	// reset output comes from a flop so it never glitches
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_ff     <= ST_HOLD;
			hold_cnt_ff  <= 4'h0;
			flags_ff     <= `RST_FLAGS_POWER_ON;
			sys_rst_n_ff <= 1'b0;
		end else begin
			state_ff     <= nxt_state;
			hold_cnt_ff  <= nxt_hold_cnt;
			flags_ff     <= nxt_flags;
			sys_rst_n_ff <= (nxt_state == ST_RUN);
		end
	end

	// ----------------------------------------
	// watchdog counter
	// ----------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wdog_cnt_ff <= 18'h00000;
		end else if (!running || wr_cause || !watchdog_enable_ff) begin
			// cause-address write restarts the count
			wdog_cnt_ff <= 18'h00000;
		end else if (wdog_cnt_ff < wdog_lim) begin
			// the count parks at its limit and never wraps
			wdog_cnt_ff <= wdog_cnt_ff + 18'h00001;
		end
	end

	// ----------------------------------------
	// write-once system options
	// ----------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			watchdog_enable_ff  <= `RST_WDOG_ENABLE;
			watchdog_timeout_select_ff  <= `RST_WDOG_TIMEOUT;
			stop_mode_enable_ff <= `RST_STOP_ENABLE;
			lock_ff  <= 1'b0;
		end else if (!running) begin
			// any device reset restores defaults and unlocks,
			// so software has to take the lock again after each restart
			watchdog_enable_ff  <= `RST_WDOG_ENABLE;
			watchdog_timeout_select_ff  <= `RST_WDOG_TIMEOUT;
			stop_mode_enable_ff <= `RST_STOP_ENABLE;
			lock_ff  <= 1'b0;
		end else if (wr_options && !lock_ff) begin
			// first write wins, later writes dropped
			watchdog_enable_ff  <= reg_wdata[`BIT_WDOG_ENABLE];
			watchdog_timeout_select_ff  <= reg_wdata[`BIT_WDOG_TIMEOUT];
			stop_mode_enable_ff <= reg_wdata[`BIT_STOP_ENABLE];
			lock_ff  <= 1'b1;
		end
	end

	// ----------------------------------------
	// clock output control
	// ----------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			clk_en_ff  <= `RST_CLKOUT_ENABLE;
			clk_div_ff <= `RST_CLKOUT_DIV;
		end else if (!running) begin
			// pin falls back to the port during any device reset
			clk_en_ff  <= `RST_CLKOUT_ENABLE;
			clk_div_ff <= `RST_CLKOUT_DIV;
		end else if (wr_clkout) begin
			clk_en_ff  <= reg_wdata[`BIT_CLKOUT_ENABLE];
			clk_div_ff <= reg_wdata[`CLKOUT_DIV_MSB:`CLKOUT_DIV_LSB];
		end
	end

	// ----------------------------------------
	// read data mux
	// ----------------------------------------
	// registered read data stands until the next read strobe
	always @* begin
		nxt_rdata = rdata_ff;
		if (reg_rd) begin
			nxt_rdata = 8'h00;
			case (reg_sel)
				`IDX_RESET_CAUSE: begin
					nxt_rdata = flags_ff;
				end
				`IDX_DEBUG_FORCE: begin
					nxt_rdata = 8'h00;
				end
				`IDX_SYSTEM_OPTIONS: begin
					// bits 3 and 2 stay zero
					nxt_rdata[`BIT_WDOG_ENABLE]  = watchdog_enable_ff;
					nxt_rdata[`BIT_WDOG_TIMEOUT] = watchdog_timeout_select_ff;
					nxt_rdata[`BIT_STOP_ENABLE]  = stop_mode_enable_ff;
				end
				`IDX_CLOCK_OUTPUT: begin
					nxt_rdata[`BIT_CLKOUT_ENABLE] = clk_en_ff;
					nxt_rdata[`CLKOUT_DIV_MSB:`CLKOUT_DIV_LSB] = clk_div_ff;
				end
				default: begin
					// indices beyond the table read zero
					nxt_rdata = 8'h00;
				end
			endcase
		end
	end

	// read data register
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_ff <= 8'h00;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// ----------------------------------------
	// divided clock and shared pin
	// ----------------------------------------
	// the divider restarts low whenever the device is held in reset
	wire div_clk;  // divided bus clock

	clock_output_divider u_div (
		.clk     (clk),
		.rstn    (rstn),
		.clear   (!running),
		.enable  (clk_en_ff),
		.divide  (clk_div_ff),
		.clk_out (div_clk)
	);

	// enabled clock output overrides port direction
	assign shared_port_pin_oe  = clk_en_ff ? 1'b1 : port_dir_out;
	assign shared_port_pin_out = clk_en_ff ? div_clk : port_data_out;

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign reg_rdata               = rdata_ff;
	assign system_reset_n          = sys_rst_n_ff;
	// legal stop only when stop mode is enabled
	assign stop_mode_enter         = running && stop_exec && stop_mode_enable_ff;
	// option bits go straight to the core that uses them
	assign watchdog_enable         = watchdog_enable_ff;
	assign watchdog_timeout_select = watchdog_timeout_select_ff;
	assign stop_mode_enable        = stop_mode_enable_ff;

endmodule

`default_nettype wire

// ### design/sys_config_defines.vh
// constants for the reset-cause and system-options register block
// assumes: included by bare name from files under design/
`ifndef SYS_CONFIG_DEFINES_VH
`define SYS_CONFIG_DEFINES_VH

// ----------------------------------------
// register indices on the register port
// ----------------------------------------
`define IDX_RESET_CAUSE     2'h0
`define IDX_DEBUG_FORCE     2'h1
`define IDX_SYSTEM_OPTIONS  2'h2
`define IDX_CLOCK_OUTPUT    2'h3

// ----------------------------------------
// reset_cause_flags bit positions
// ----------------------------------------
`define BIT_POWER_ON        7
`define BIT_PIN             6
`define BIT_WATCHDOG        5
`define BIT_ILLEGAL_OPCODE  4
`define BIT_CLOCK_GEN       2
`define BIT_LOW_VOLTAGE     1

// ----------------------------------------
// other field positions
// ----------------------------------------
`define BIT_FORCE_RESET     0
`define BIT_WDOG_ENABLE     7
`define BIT_WDOG_TIMEOUT    6
`define BIT_STOP_ENABLE     5
`define BIT_CLKOUT_ENABLE   4
`define CLKOUT_DIV_MSB      2
`define CLKOUT_DIV_LSB      0

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_FLAGS_POWER_ON  8'h82
`define RST_WDOG_ENABLE     1'b1
`define RST_WDOG_TIMEOUT    1'b1
`define RST_STOP_ENABLE     1'b0
`define RST_CLKOUT_ENABLE   1'b0
`define RST_CLKOUT_DIV      3'h0

// ----------------------------------------
// timing counts in bus clock cycles
// ----------------------------------------
`define WDOG_SHORT_CYCLES   8192
`define WDOG_LONG_CYCLES    262144
`define RST_HOLD_CYCLES     4'hF

`endif

// ### design/clock_output_divider.v
// divided bus clock generator for the shared port pin
// assumes: one clock, asynchronous active-low reset, sync clear
`timescale 1ns/1ps
`default_nettype none

module clock_output_divider (
	input  wire       clk,
	input  wire       rstn,
	input  wire       clear,
	input  wire       enable,
	input  wire [2:0] divide,
	output wire       clk_out
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg [2:0] cnt_ff;    // cycles since last toggle
	reg       level_ff;  // current output level

	// ----------------------------------------
	// toggle every divide cycles, zero holds low
	// ----------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_ff   <= 3'h0;
			level_ff <= 1'b0;
		end else if (clear || !enable || divide == 3'h0) begin
			cnt_ff   <= 3'h0;
			level_ff <= 1'b0;
		end else if (cnt_ff >= divide - 3'h1) begin
			cnt_ff   <= 3'h0;
			level_ff <= ~level_ff;
		end else begin
			cnt_ff   <= cnt_ff + 3'h1;
		end
	end

	assign clk_out = level_ff;

endmodule

`default_nettype wire

// ### verification/sys_config_chk.sv
// checker: assertions on the ports of the system configuration block
// assumes: bound to sys_config, one clock, rstn async active low
`timescale 1ns/1ps
`default_nettype none

module sys_config_chk #(
	parameter integer WDOG_SHORT_CYCLES = 16,
	parameter integer WDOG_LONG_CYCLES  = 32
) (
	input wire logic       clk,
	input wire logic       rstn,
	input wire logic [1:0] reg_sel,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       dbg_wr,
	input wire logic [1:0] dbg_sel,
	input wire logic [7:0] dbg_wdata,
	input wire logic       reset_pin_n,
	input wire logic       clock_gen_reset_req,
	input wire logic       stop_exec,
	input wire logic       background_instruction,
	input wire logic       background_mode_enable,
	input wire logic       port_dir_out,
	input wire logic       shared_port_pin_oe,
	input wire logic       system_reset_n,
	input wire logic       stop_mode_enter,
	input wire logic       watchdog_enable,
	input wire logic       watchdog_timeout_select,
	input wire logic       stop_mode_enable
);
	// ----------------------------------------
	// common clock and reset
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	// ----------------------------------------
	// reset causes, stop gating, hold span and option defaults
	// ----------------------------------------
	a_force_resets: assert property (system_reset_n && dbg_wr && dbg_sel == 2'h1 && dbg_wdata[0]
		|=> !system_reset_n) else $error("debug force did not reset");
	a_pin_resets: assert property (system_reset_n && !reset_pin_n |=> !system_reset_n)
		else $error("reset pin did not reset");
	a_clkgen_resets: assert property (system_reset_n && clock_gen_reset_req |=> !system_reset_n)
		else $error("clock generator request did not reset");
	a_stop_illegal: assert property (system_reset_n && stop_exec && !stop_mode_enable
		|=> !system_reset_n) else $error("disabled stop did not reset");
	a_background_instruction_illegal: assert property (system_reset_n && background_instruction
		&& !background_mode_enable |=> !system_reset_n) else $error("illegal background no reset");
	a_stop_gated: assert property (stop_mode_enter |-> stop_exec && stop_mode_enable)
		else $error("stop entered while disabled");
	a_hold_span: assert property ($fell(system_reset_n) |-> !system_reset_n[*8])
		else $error("device reset too short");
	a_option_defaults: assert property ($rose(system_reset_n) |-> watchdog_enable
		&& watchdog_timeout_select && !stop_mode_enable) else $error("option defaults wrong");

	// ----------------------------------------
	// read values and pin drive
	// ----------------------------------------
	a_force_reads_zero: assert property (system_reset_n && reg_rd && reg_sel == 2'h1
		|=> reg_rdata == 8'h00) else $error("force register read not zero");
	a_options_unused: assert property (system_reset_n && reg_rd && reg_sel == 2'h2
		|=> reg_rdata[3:2] == 2'h0) else $error("options unused bits not zero");
	a_cause_unused: assert property (system_reset_n && reg_rd && reg_sel == 2'h0
		|=> !reg_rdata[3] && !reg_rdata[0]) else $error("cause unused bits not zero");
	a_pin_drive: assert property (port_dir_out |-> shared_port_pin_oe)
		else $error("pin not driven as output");
endmodule

bind sys_config sys_config_chk #(
	.WDOG_SHORT_CYCLES(WDOG_SHORT_CYCLES),
	.WDOG_LONG_CYCLES (WDOG_LONG_CYCLES)
) u_sys_config_chk (.clk(clk), .rstn(rstn), .reg_sel(reg_sel), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .dbg_wr(dbg_wr), .dbg_sel(dbg_sel), .dbg_wdata(dbg_wdata),
	.reset_pin_n(reset_pin_n), .clock_gen_reset_req(clock_gen_reset_req), .stop_exec(stop_exec),
	.background_instruction(background_instruction), .port_dir_out(port_dir_out),
	.background_mode_enable(background_mode_enable), .shared_port_pin_oe(shared_port_pin_oe),
	.system_reset_n(system_reset_n), .stop_mode_enter(stop_mode_enter),
	.watchdog_enable(watchdog_enable), .watchdog_timeout_select(watchdog_timeout_select),
	.stop_mode_enable(stop_mode_enable));
`default_nettype wire

// ### verification/cpu_host_model.sv
// processor software and debug host model on the register ports
// assumes: requests are taken on the rising clock edge
`timescale 1ns/1ps
`default_nettype none

module cpu_host_model (
	input  wire logic       clk,
	input  wire logic [7:0] reg_rdata,
	output logic      [1:0] reg_sel,
	output logic            reg_wr,
	output logic            reg_rd,
	output logic      [7:0] reg_wdata,
	output logic            dbg_wr,
	output logic      [1:0] dbg_sel,
	output logic      [7:0] dbg_wdata
);
	// idle ports at time zero
	initial begin
		reg_sel = 2'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
		dbg_wr = 1'b0;
		dbg_sel = 2'h0;
		dbg_wdata = 8'h00;
	end

	// one processor write, held across one rising edge
	task cpu_write(input logic [1:0] sel, input logic [7:0] data);
		@(negedge clk);
		reg_sel = sel;
		reg_wdata = data;
		reg_wr = 1'b1;
		@(negedge clk);
		reg_wr = 1'b0;
		reg_wdata = ~data;	// released data shows garbage
	endtask

	// one processor read, data taken one cycle later
	task cpu_read(input logic [1:0] sel, output logic [7:0] data);
		@(negedge clk);
		reg_sel = sel;
		reg_rd = 1'b1;
		@(negedge clk);
		reg_rd = 1'b0;
		data = reg_rdata;
	endtask

	// debug host reaches only the force register
	task dbg_force(input logic [7:0] data);
		@(negedge clk);
		dbg_sel = 2'h1;
		dbg_wdata = data;
		dbg_wr = 1'b1;
		@(negedge clk);
		dbg_wr = 1'b0;
		dbg_wdata = ~data;
	endtask
endmodule
`default_nettype wire

// ### verification/tb_reset_cause_and_system_options.sv
// testbench for the system configuration block
// assumes: design/ on the include path, checker bound separately
`timescale 1ns/1ps
`default_nettype none
`include "sys_config_defines.vh"

module tb_reset_cause_and_system_options;
	logic       clk, rstn, reset_pin_n, clock_gen_reset_req, illegal_opcode_req, stop_exec;
	logic       background_instruction, background_mode_enable, low_voltage_trip;
	logic       low_voltage_reset_enable, low_voltage_stop_enable, port_data_out, port_dir_out;
	wire  [1:0] reg_sel, dbg_sel;
	wire  [7:0] reg_wdata, reg_rdata, dbg_wdata;
	wire        reg_wr, reg_rd, dbg_wr, pin_out, pin_oe, system_reset_n, stop_mode_enter;
	integer     fail_count, checks_done, k, n, j;
	logic [7:0] rd;
	logic [7:0] exp_flags [0:5];	// expected flags per cause

	sys_config #(.WDOG_SHORT_CYCLES(16), .WDOG_LONG_CYCLES(32)) u_sys_config (.clk(clk),
		.rstn(rstn), .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .dbg_wr(dbg_wr), .dbg_sel(dbg_sel), .dbg_wdata(dbg_wdata),
		.reset_pin_n(reset_pin_n), .clock_gen_reset_req(clock_gen_reset_req),
		.illegal_opcode_req(illegal_opcode_req), .stop_exec(stop_exec),
		.background_instruction(background_instruction), .low_voltage_trip(low_voltage_trip),
		.background_mode_enable(background_mode_enable), .port_data_out(port_data_out),
		.low_voltage_reset_enable(low_voltage_reset_enable), .port_dir_out(port_dir_out),
		.low_voltage_stop_enable(low_voltage_stop_enable), .shared_port_pin_out(pin_out),
		.shared_port_pin_oe(pin_oe), .system_reset_n(system_reset_n),
		.stop_mode_enter(stop_mode_enter), .watchdog_enable(), .watchdog_timeout_select(),
		.stop_mode_enable());
	cpu_host_model u_cpu_host_model (.clk(clk), .reg_rdata(reg_rdata), .reg_sel(reg_sel),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .dbg_wr(dbg_wr),
		.dbg_sel(dbg_sel), .dbg_wdata(dbg_wdata));

	// bus clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// compare and count
	task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// verdict
	task finish_test;
		if (fail_count == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// wait out the reset hold under a bound
	task wait_run;
		n = 0;
		while (system_reset_n !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		check("running", {7'h0, system_reset_n}, 8'h01);
	endtask

	// reset defaults, write-once options, ignored writes
	task t_power_on;
		u_cpu_host_model.cpu_read(`IDX_RESET_CAUSE, rd);
		check("por flags", rd, 8'h82);
		u_cpu_host_model.cpu_read(`IDX_SYSTEM_OPTIONS, rd);
		check("opt default", rd, 8'hC0);
		u_cpu_host_model.cpu_read(`IDX_DEBUG_FORCE, rd);
		check("force read", rd, 8'h00);
		u_cpu_host_model.cpu_write(`IDX_SYSTEM_OPTIONS, 8'h6F);
		u_cpu_host_model.cpu_write(`IDX_SYSTEM_OPTIONS, 8'hCF);
		u_cpu_host_model.cpu_read(`IDX_SYSTEM_OPTIONS, rd);
		check("opt once", rd, 8'h60);
		u_cpu_host_model.cpu_write(`IDX_DEBUG_FORCE, 8'hFF);
		@(negedge clk);
		stop_exec = 1'b1;
		#1 check("stop enter", {7'h0, stop_mode_enter}, 8'h01);
		@(negedge clk);
		stop_exec = 1'b0;
		repeat (40) @(negedge clk);
		check("no reset", {7'h0, system_reset_n}, 8'h01);
	endtask

	// pin, clock generator, illegal opcode, stop, background and debug force resets in turn, flags of earlier causes cleared
	task t_causes;
		for (k = 0; k < 6; k++) begin
			if (k == 5)
				u_cpu_host_model.dbg_force(8'h01);
			else begin
				@(negedge clk);
				reset_pin_n = (k != 0);
				clock_gen_reset_req = (k == 1);
				illegal_opcode_req = (k == 2);
				stop_exec = (k == 3);
				background_instruction = (k == 4);
				@(negedge clk);
				{clock_gen_reset_req, illegal_opcode_req, stop_exec, background_instruction} = 4'h0;
				reset_pin_n = 1'b1;
			end
			check("reset taken", {7'h0, system_reset_n}, 8'h00);
			wait_run();
			u_cpu_host_model.cpu_write(`IDX_SYSTEM_OPTIONS, 8'h00);
			u_cpu_host_model.cpu_read(`IDX_RESET_CAUSE, rd);
			check("cause flags", rd, exp_flags[k]);
		end
	endtask

	// low-voltage reset needs both enables
	task t_low_voltage;
		low_voltage_reset_enable = 1'b1;
		low_voltage_trip = 1'b1;
		repeat (3) @(negedge clk);
		check("lv one enable", {7'h0, system_reset_n}, 8'h01);
		low_voltage_stop_enable = 1'b1;
		@(negedge clk);
		low_voltage_trip = 1'b0;
		wait_run();
		u_cpu_host_model.cpu_write(`IDX_SYSTEM_OPTIONS, 8'h00);
		u_cpu_host_model.cpu_read(`IDX_RESET_CAUSE, rd);
		check("lv flags", rd, 8'h02);
	endtask

	// divided clock on the shared pin
	task t_clock_out;
		port_data_out = 1'b1;
		@(negedge clk);
		check("pin port", {6'h0, pin_oe, pin_out}, 8'h01);
		u_cpu_host_model.cpu_write(`IDX_CLOCK_OUTPUT, 8'h13);
		for (n = 0; n < 20 && pin_out !== 1'b1; n++) @(negedge clk);
		for (j = 0; j < 20 && pin_out === 1'b1; j++) @(negedge clk);
		for (k = 0; k < 20 && pin_out === 1'b0; k++) @(negedge clk);
		check("half periods", {j[3:0], k[3:0]}, 8'h33);
		check("pin output", {7'h0, pin_oe}, 8'h01);
		u_cpu_host_model.cpu_write(`IDX_CLOCK_OUTPUT, 8'h10);
		rd = 8'h00;
		repeat (8) begin
			@(negedge clk);
			rd = rd | {7'h0, pin_out};
		end
		check("pin low", rd, 8'h00);
		u_cpu_host_model.cpu_write(`IDX_CLOCK_OUTPUT, 8'h00);
		@(negedge clk);
		check("pin released", {7'h0, pin_oe}, 8'h00);
	endtask

	// forced reset unlocks options; restarts hold the watchdog off, then it times out
	task t_watchdog;
		u_cpu_host_model.dbg_force(8'h01);
		wait_run();
		for (j = 0; j < 2; j++) begin
			u_cpu_host_model.cpu_write(`IDX_SYSTEM_OPTIONS, j ? 8'hC0 : 8'h80);
			repeat (4) begin
				repeat (10) @(negedge clk);
				u_cpu_host_model.cpu_write(`IDX_RESET_CAUSE, 8'hFF);
			end
			u_cpu_host_model.cpu_read(`IDX_RESET_CAUSE, rd);
			check("restart keeps", rd, j ? 8'h20 : 8'h00);
			u_cpu_host_model.cpu_write(`IDX_RESET_CAUSE, 8'hFF);
			for (n = 0; n < 400 && system_reset_n === 1'b1; n++) @(negedge clk);
			check("timeout", {7'h0, n >= (j ? 30 : 14) && n <= (j ? 34 : 18)}, 8'h01);
			wait_run();
			u_cpu_host_model.cpu_read(`IDX_RESET_CAUSE, rd);
			check("wdog flag", rd, 8'h20);
		end
	endtask

	// watchdog on the whole run
	initial begin
		#(5000 * 100);
		fail_count++;
		finish_test();
	end

	// main sequence
	initial begin
		{fail_count, checks_done} = 0;
		exp_flags = '{8'h40, 8'h04, 8'h10, 8'h10, 8'h10, 8'h00};
		{rstn, clock_gen_reset_req, illegal_opcode_req, stop_exec, background_instruction} = 5'h0;
		{background_mode_enable, low_voltage_trip, low_voltage_reset_enable} = 3'h0;
		{low_voltage_stop_enable, port_data_out, port_dir_out} = 3'h0;
		reset_pin_n = 1'b1;
		repeat (8) @(negedge clk);
		rstn = 1'b1;
		wait_run();
		t_power_on();
		t_causes();
		t_low_voltage();
		t_clock_out();
		t_watchdog();
		finish_test();
	end
endmodule
`default_nettype wire
